// ---- design/pplc_map.svh ----
// Address indices, field positions and reset values of the PHY port
// control registers. Assumes it is included by bare name, once per unit.
`ifndef PPLC_MAP_SVH
`define PPLC_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PPLC_IDX_P1_CTL_A   8'h1C
`define PPLC_IDX_P1_CTL_B   8'h1D
`define PPLC_IDX_P2_CTL_A   8'h2C
`define PPLC_IDX_P2_CTL_B   8'h2D
`define PPLC_IDX_P3_CTL_A   8'h3C
`define PPLC_IDX_P3_CTL_B   8'h3D

// ----------------------------------------------------------------------
// Control A field positions
// ----------------------------------------------------------------------
`define PPLC_A_AN_EN        7
`define PPLC_A_SPEED        6
`define PPLC_A_DUPLEX       5
`define PPLC_A_PAUSE        4
`define PPLC_A_ADV_HI       3

// ----------------------------------------------------------------------
// Control B field positions
// ----------------------------------------------------------------------
`define PPLC_B_LED_OFF      7
`define PPLC_B_TX_OFF       6
`define PPLC_B_RESTART      5
`define PPLC_B_NO_FEF       4
`define PPLC_B_PWR_DOWN     3
`define PPLC_B_NO_AMDIX     2
`define PPLC_B_FORCE_MDI    1
`define PPLC_B_LOOPBACK     0

// ----------------------------------------------------------------------
// Reset values and bus constants
// ----------------------------------------------------------------------
`define PPLC_RST_CTL_A      8'hFF
`define PPLC_RST_CTL_B      8'h00
`define PPLC_RST_ON         2'h3
`define PPLC_ADV_ALL        4'hF
`define PPLC_WORD_ALIGN     2'h0
`define PPLC_RDATA_PAD      24'h000000

`endif

// ---- design/pplc_pkg.sv ----
// Types shared by the PHY port control register bank.
// Assumes nothing of its surroundings; holds types only.
package pplc_pkg;

    // Kind of register an address selects
    typedef enum logic [1:0] {
        PPLC_KIND_NONE = 2'h0,
        PPLC_KIND_A    = 2'h1,
        PPLC_KIND_B    = 2'h3,
        PPLC_KIND_RSVD = 2'h2
    } pplc_kind_t;

    // Result of an address decode
    typedef struct packed {
        pplc_kind_t kind;   // Register kind
        logic       port;   // 0 = first PHY port, 1 = second
    } pplc_dec_t;

    // All state of the bank
    typedef struct packed {
        logic [1:0][7:0] ctl_a;      // Link control A per port
        logic [1:0][7:0] ctl_b;      // Link control B per port
        logic            strap_done; // Duplex straps already taken
        logic            pready;     // Bus answer
        logic            pslverr;    // Bus error answer
        logic [31:0]     prdata;     // Read data
        logic [1:0]      an_en;      // Negotiation enable out
        logic [1:0]      full_dup;   // Working duplex out
        logic [1:0]      spd100;     // Working speed out
        logic [1:0]      adv_pause;  // Pause advertisement out
        logic [1:0][3:0] adv;        // Ability advertisement out
        logic [1:0]      led1;       // LED one pin out
        logic [1:0]      led0;       // LED zero pin out
        logic [1:0]      tx_en;      // Transmitter enable out
        logic [1:0]      restart;    // Negotiation restart pulse out
        logic [1:0]      fef_en;     // Far-end fault enable out
        logic [1:0]      amdix_en;   // Auto crossover enable out
        logic [1:0]      mdi;        // 1 = MDI, 0 = MDI-X out
        logic [1:0]      pwr_down;   // Power down out
        logic [1:0]      loop;       // Loopback out
    } pplc_state_t;

endpackage

// ---- design/pplc_regs.sv ----
// Per-port link control registers for the two copper PHY ports,
// reached over APB, steering the PHY link logic of each port.
// Assumes APB signals and PHY side inputs synchronous to clk.
//
// How it works
// - Forced duplex bit applies when negotiation off/failed
// - Duplex bit reset value taken from strap
// - Bit 4 advertises pause, reset one
// - Bits 3..0 advertise four abilities, reset ones
// - LED off bit drives both LEDs high
// - Transmitter-off bit disables port transmitter
// - Writing one restarts auto-negotiation
// - Bit 4 disables far-end fault detect/send
// - Bit 2 disables automatic crossover
// - Forced crossover: bit 1 selects MDI
// - Negotiation enable bit; forced bits otherwise
`include "pplc_map.svh"

module pplc_regs (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [9:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Straps, sampled once after reset
    input  wire logic        duplex_strap_port1,
    input  wire logic        duplex_strap_port2,
    // PHY side status, index 0 = port 1
    input  wire logic [1:0]  autoneg_done,
    input  wire logic [1:0]  autoneg_failed,
    input  wire logic [1:0]  partner_full_duplex,
    input  wire logic [1:0]  partner_speed_100,
    input  wire logic [1:0]  auto_mdi_detect,
    input  wire logic [1:0]  led_one_raw,
    input  wire logic [1:0]  led_zero_raw,
    // PHY side controls
    output logic [1:0]       autoneg_enable,
    output logic [1:0]       full_duplex,
    output logic [1:0]       speed_100,
    output logic [1:0]       advert_pause,
    output logic [7:0]       advert_ability,
    output logic [1:0]       port_led_one,
    output logic [1:0]       port_led_zero,
    output logic [1:0]       tx_enable,
    output logic [1:0]       autoneg_restart,
    output logic [1:0]       far_end_fault_enable,
    output logic [1:0]       auto_mdix_enable,
    output logic [1:0]       mdi_mode,
    output logic [1:0]       power_down,
    output logic [1:0]       loopback
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta;   // First stage, read only by the second
    logic rst_n;      // Released copy used everywhere

    // Assert at once, release two edges later
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Used for both read and write paths
    function automatic pplc_pkg::pplc_dec_t decode(input logic [9:0] a);
        pplc_pkg::pplc_dec_t d;
        d.kind = pplc_pkg::PPLC_KIND_NONE;
        d.port = 1'b0;
        if (a[1:0] == `PPLC_WORD_ALIGN) begin
            unique case (a[9:2])
                `PPLC_IDX_P1_CTL_A: d.kind = pplc_pkg::PPLC_KIND_A;
                `PPLC_IDX_P1_CTL_B: d.kind = pplc_pkg::PPLC_KIND_B;
                `PPLC_IDX_P2_CTL_A: begin
                    d.kind = pplc_pkg::PPLC_KIND_A;
                    d.port = 1'b1;
                end
                `PPLC_IDX_P2_CTL_B: begin
                    d.kind = pplc_pkg::PPLC_KIND_B;
                    d.port = 1'b1;
                end
                `PPLC_IDX_P3_CTL_A,
                `PPLC_IDX_P3_CTL_B: d.kind = pplc_pkg::PPLC_KIND_RSVD;
                default:            d.kind = pplc_pkg::PPLC_KIND_NONE;
            endcase
        end
        return d;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pplc_pkg::pplc_state_t st;       // Registered state
    pplc_pkg::pplc_state_t next_st;  // Next state
    pplc_pkg::pplc_dec_t   dec;      // Current address decode
    logic                  wr_take;  // Write commits this edge
    logic [1:0]            straps;   // Straps by port index

    // Outputs enable the PHY at reset; LEDs start dark
    localparam pplc_pkg::pplc_state_t RST_STATE = '{
        ctl_a:     {2{`PPLC_RST_CTL_A}},
        ctl_b:     {2{`PPLC_RST_CTL_B}},
        an_en:     `PPLC_RST_ON,
        full_dup:  `PPLC_RST_ON,
        spd100:    `PPLC_RST_ON,
        adv_pause: `PPLC_RST_ON,
        adv:       {2{`PPLC_ADV_ALL}},
        led1:      `PPLC_RST_ON,
        led0:      `PPLC_RST_ON,
        tx_en:     `PPLC_RST_ON,
        fef_en:    `PPLC_RST_ON,
        amdix_en:  `PPLC_RST_ON,
        default:   '0
    };

    assign dec     = decode(paddr);
    assign straps  = {duplex_strap_port2, duplex_strap_port1};
    // Master samples pready at this edge, so the write lands now
    assign wr_take = psel && penable && pready && pwrite;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Restart is a one-cycle pulse
        next_st.restart = 2'h0;

        // Straps land on the first edge after release
        if (!st.strap_done) begin
            next_st.strap_done = 1'b1;
            for (int p = 0; p < 2; p++) begin
                next_st.ctl_a[p][`PPLC_A_DUPLEX] = straps[p];
            end
        end

        // Bus answer: one wait state, then pready for one cycle
        next_st.pready  = 1'b0;
        next_st.pslverr = 1'b0;
        if (psel && penable && !st.pready) begin
            next_st.pready = 1'b1;
            next_st.prdata = {`PPLC_RDATA_PAD, 8'h00};
            unique case (dec.kind)
                pplc_pkg::PPLC_KIND_A:
                    next_st.prdata = {`PPLC_RDATA_PAD, st.ctl_a[dec.port]};
                pplc_pkg::PPLC_KIND_B:
                    next_st.prdata = {`PPLC_RDATA_PAD, st.ctl_b[dec.port]};
                // Third port reads zero, no error
                pplc_pkg::PPLC_KIND_RSVD: next_st.prdata = {`PPLC_RDATA_PAD, 8'h00};
                // Unmapped address answers with an error
                pplc_pkg::PPLC_KIND_NONE: next_st.pslverr = 1'b1;
            endcase
        end

        // Register writes; reserved and unmapped do nothing
        if (wr_take) begin
            if (dec.kind == pplc_pkg::PPLC_KIND_A) begin
                next_st.ctl_a[dec.port] = pwdata[7:0];
            end else if (dec.kind == pplc_pkg::PPLC_KIND_B) begin
                next_st.ctl_b[dec.port] = pwdata[7:0];
                // Each write of one restarts negotiation
                next_st.restart[dec.port] = pwdata[`PPLC_B_RESTART];
            end
        end

        // Per-port controls, each port from its own copy
        for (int p = 0; p < 2; p++) begin
            // Negotiation enable
            next_st.an_en[p] = st.ctl_a[p][`PPLC_A_AN_EN];
            // Negotiated result only when on and not failed
            if (st.ctl_a[p][`PPLC_A_AN_EN] && !autoneg_failed[p] && autoneg_done[p]) begin
                next_st.full_dup[p] = partner_full_duplex[p];
                next_st.spd100[p]   = partner_speed_100[p];
            end else if (!st.ctl_a[p][`PPLC_A_AN_EN] || autoneg_failed[p]) begin
                // Forced bits; a stale strap misreports here
                next_st.full_dup[p] = st.ctl_a[p][`PPLC_A_DUPLEX];
                next_st.spd100[p]   = st.ctl_a[p][`PPLC_A_SPEED];
            end
            // Advertisement
            next_st.adv_pause[p] = st.ctl_a[p][`PPLC_A_PAUSE];
            next_st.adv[p]       = st.ctl_a[p][`PPLC_A_ADV_HI:0];
            // LEDs driven high when blanked
            next_st.led1[p] = st.ctl_b[p][`PPLC_B_LED_OFF] | led_one_raw[p];
            next_st.led0[p] = st.ctl_b[p][`PPLC_B_LED_OFF] | led_zero_raw[p];
            // Transmitter
            next_st.tx_en[p] = !st.ctl_b[p][`PPLC_B_TX_OFF];
            // Far-end fault detect and send together
            next_st.fef_en[p] = !st.ctl_b[p][`PPLC_B_NO_FEF];
            // Crossover selection
            next_st.amdix_en[p] = !st.ctl_b[p][`PPLC_B_NO_AMDIX];
            next_st.mdi[p] = st.ctl_b[p][`PPLC_B_NO_AMDIX] ?
                             st.ctl_b[p][`PPLC_B_FORCE_MDI] : auto_mdi_detect[p];
            // Held only for the PHY that acts on them
            next_st.pwr_down[p] = st.ctl_b[p][`PPLC_B_PWR_DOWN];
            next_st.loop[p]     = st.ctl_b[p][`PPLC_B_LOOPBACK];
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= RST_STATE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all straight from the state register
    // ------------------------------------------------------------------
    assign pready               = st.pready;
    assign prdata               = st.prdata;
    assign pslverr              = st.pslverr;
    assign autoneg_enable       = st.an_en;
    assign full_duplex          = st.full_dup;
    assign speed_100            = st.spd100;
    assign advert_pause         = st.adv_pause;
    assign advert_ability       = st.adv;
    assign port_led_one         = st.led1;
    assign port_led_zero        = st.led0;
    assign tx_enable            = st.tx_en;
    assign autoneg_restart      = st.restart;
    assign far_end_fault_enable = st.fef_en;
    assign auto_mdix_enable     = st.amdix_en;
    assign mdi_mode             = st.mdi;
    assign power_down           = st.pwr_down;
    assign loopback             = st.loop;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Bus answers exactly one cycle after the access phase opens
    a_apb_answer: assert property (
        psel && penable && !pready |=> pready ##1 !pready)
        else $error("pready not one-cycle after access");

    // Straps land on the first edge
    a_duplex_strap: assert property (
        $rose(st.strap_done) |-> st.ctl_a[0][`PPLC_A_DUPLEX] == $past(duplex_strap_port1)
                              && st.ctl_a[1][`PPLC_A_DUPLEX] == $past(duplex_strap_port2))
        else $error("duplex strap not sampled");

    // Reserved port writes change nothing
    a_port3_inert: assert property (
        wr_take && dec.kind == pplc_pkg::PPLC_KIND_RSVD |=> $stable(st.ctl_a) && $stable(st.ctl_b))
        else $error("reserved write changed state");

    // Unmapped address errors with the answer
    a_unmapped_err: assert property (
        psel && penable && !pready && dec.kind == pplc_pkg::PPLC_KIND_NONE |=> pslverr && pready)
        else $error("unmapped access without error");

    // Error rides on answer
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without answer");

    for (genvar p = 0; p < 2; p++) begin : g_chk
        // Forced mode
        a_forced_duplex: assert property (
            !st.ctl_a[p][`PPLC_A_AN_EN] || autoneg_failed[p]
            |=> full_duplex[p] == $past(st.ctl_a[p][`PPLC_A_DUPLEX]))
            else $error("forced duplex not applied");

        // Negotiated mode
        a_negotiated: assert property (
            st.ctl_a[p][`PPLC_A_AN_EN] && autoneg_done[p] && !autoneg_failed[p]
            |=> full_duplex[p] == $past(partner_full_duplex[p]))
            else $error("negotiated duplex wrong");

        a_advertise: assert property (
            ##1 {advert_pause[p], advert_ability[p*4 +: 4]}
            == $past(st.ctl_a[p][`PPLC_A_PAUSE:0]))
            else $error("advertisement mismatch");

        a_led_blank: assert property (
            st.ctl_b[p][`PPLC_B_LED_OFF] |=> port_led_one[p] && port_led_zero[p])
            else $error("LEDs not dark while blanked");

        // LEDs follow PHY
        a_led_follow: assert property (
            !st.ctl_b[p][`PPLC_B_LED_OFF] |=> port_led_one[p] == $past(led_one_raw[p])
            && port_led_zero[p] == $past(led_zero_raw[p]))
            else $error("LEDs not following");

        a_tx_off: assert property (
            st.ctl_b[p][`PPLC_B_TX_OFF] |=> !tx_enable[p])
            else $error("transmitter not disabled");

        // Restart pulse
        a_restart_pulse: assert property (
            wr_take && dec.kind == pplc_pkg::PPLC_KIND_B && dec.port == p
            && pwdata[`PPLC_B_RESTART] |=> autoneg_restart[p] ##1 !autoneg_restart[p])
            else $error("restart pulse wrong");

        a_fef_ctl: assert property (
            ##1 far_end_fault_enable[p] != $past(st.ctl_b[p][`PPLC_B_NO_FEF]))
            else $error("far-end fault control wrong");

        a_mdix_force: assert property (
            st.ctl_b[p][`PPLC_B_NO_AMDIX] |=> !auto_mdix_enable[p]
            && mdi_mode[p] == $past(st.ctl_b[p][`PPLC_B_FORCE_MDI]))
            else $error("forced crossover wrong");

        a_mdix_auto: assert property (
            !st.ctl_b[p][`PPLC_B_NO_AMDIX] |=> mdi_mode[p] == $past(auto_mdi_detect[p]))
            else $error("auto crossover not followed");

        a_an_enable: assert property (
            ##1 autoneg_enable[p] == $past(st.ctl_a[p][`PPLC_A_AN_EN]))
            else $error("negotiation enable mismatch");
    end

    // Main scenarios
    c_write_b:   cover property (wr_take && dec.kind == pplc_pkg::PPLC_KIND_B);
    c_read_a:    cover property (psel && penable && pready && !pwrite
                                 && dec.kind == pplc_pkg::PPLC_KIND_A);
    c_restart:   cover property (autoneg_restart[1]);
    c_led_blank: cover property (st.ctl_b[0][`PPLC_B_LED_OFF] ##1 port_led_one[0]);
    c_unmapped:  cover property (pslverr);

endmodule

// ---- dv/pplc_partner.sv ----
// Link partner model for both PHY ports: answers each negotiation start.
// Assumes restart pulses and enables come from the control bank.
module pplc_partner #(
    parameter int DELAY = 8             // Cycles one negotiation takes
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       resetn,
    // Bank controls
    input  wire logic [1:0] autoneg_restart,
    input  wire logic [1:0] autoneg_enable,
    input  wire logic [7:0] advert_ability,
    // Scenario settings from the bench
    input  wire logic [1:0] cfg_fail,
    input  wire logic [1:0] cfg_fd,
    input  wire logic [1:0] cfg_100,
    // Negotiation results
    output logic [1:0]      autoneg_done,
    output logic [1:0]      autoneg_failed,
    output logic [1:0]      partner_full_duplex,
    output logic [1:0]      partner_speed_100
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] en_q;                   // Enable seen last cycle
    int         cnt [2];                // Cycles left per port
    // Results toggle while a negotiation counts down, so early use shows
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_q <= 2'h0;
            cnt <= '{DELAY, DELAY};
            autoneg_done <= 2'h0;
            autoneg_failed <= 2'h0;
            partner_full_duplex <= 2'h0;
            partner_speed_100 <= 2'h0;
        end else begin
            en_q <= autoneg_enable;
            for (int p = 0; p < 2; p++) begin
                if (autoneg_restart[p] || !(autoneg_enable[p] && en_q[p])) begin
                    cnt[p] <= DELAY;
                    autoneg_done[p] <= 1'b0;
                    autoneg_failed[p] <= 1'b0;
                end else if (cnt[p] == 1) begin
                    cnt[p] <= 0;
                    autoneg_done[p] <= !cfg_fail[p];
                    autoneg_failed[p] <= cfg_fail[p];
                    partner_full_duplex[p] <= cfg_fd[p] &
                        (advert_ability[4*p+3] | advert_ability[4*p+1]);
                    partner_speed_100[p] <= cfg_100[p] &
                        (advert_ability[4*p+3] | advert_ability[4*p+2]);
                end else if (cnt[p] > 1) begin
                    cnt[p] <= cnt[p] - 1;
                    partner_full_duplex[p] <= !partner_full_duplex[p];
                    partner_speed_100[p] <= !partner_speed_100[p];
                end
            end
        end
    end
endmodule

// ---- dv/pplc_regs_tb.sv ----
// Self-checking bench for the PHY port control bank: APB master, random
// and corner cases. Assumes the bank and the partner model compile first.
`include "pplc_map.svh"
module pplc_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------
    // Signals
    // ----------------------------
    logic        clk = 1'b0, resetn = 1'b0;               // Clock, board reset
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0; // APB request
    logic [9:0]  paddr = 10'h000;                          // APB address
    logic [31:0] pwdata = 32'h00000000, prdata;            // APB data
    logic        pready, pslverr, duplex_strap_port1, duplex_strap_port2;
    logic [1:0]  autoneg_done, autoneg_failed, partner_full_duplex, partner_speed_100;
    logic [1:0]  auto_mdi_detect = 2'h0, led_one_raw = 2'h0, led_zero_raw = 2'h0;
    logic [1:0]  cfg_fail = 2'h0, cfg_fd = 2'h0, cfg_100 = 2'h0; // Partner setup
    logic [1:0]  autoneg_enable, full_duplex, speed_100, advert_pause, port_led_one;
    logic [1:0]  port_led_zero, tx_enable, autoneg_restart, far_end_fault_enable;
    logic [1:0]  auto_mdix_enable, mdi_mode, power_down, loopback;
    logic [7:0]  advert_ability;
    logic [7:0]  sa [2], sb [2];                           // Expected contents
    int          seed = 9029, n_errors = 0, comparisons = 0, cycles = 0;
    int          n_rst [2] = '{0, 0}, e_rst [2] = '{0, 0}; // Restart pulses
    pplc_regs uut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .duplex_strap_port1(duplex_strap_port1),
        .duplex_strap_port2(duplex_strap_port2), .autoneg_done(autoneg_done),
        .autoneg_failed(autoneg_failed), .partner_full_duplex(partner_full_duplex),
        .partner_speed_100(partner_speed_100), .auto_mdi_detect(auto_mdi_detect),
        .led_one_raw(led_one_raw), .led_zero_raw(led_zero_raw),
        .autoneg_enable(autoneg_enable), .full_duplex(full_duplex),
        .speed_100(speed_100), .advert_pause(advert_pause),
        .advert_ability(advert_ability), .port_led_one(port_led_one),
        .port_led_zero(port_led_zero), .tx_enable(tx_enable),
        .autoneg_restart(autoneg_restart), .far_end_fault_enable(far_end_fault_enable),
        .auto_mdix_enable(auto_mdix_enable), .mdi_mode(mdi_mode),
        .power_down(power_down), .loopback(loopback));
    pplc_partner u_partner (.clk(clk), .resetn(resetn), .autoneg_restart(autoneg_restart),
        .autoneg_enable(autoneg_enable), .advert_ability(advert_ability),
        .cfg_fail(cfg_fail), .cfg_fd(cfg_fd), .cfg_100(cfg_100),
        .autoneg_done(autoneg_done), .autoneg_failed(autoneg_failed),
        .partner_full_duplex(partner_full_duplex), .partner_speed_100(partner_speed_100));
    // ----------------------------
    // Clock, pulse count, timeout
    // ----------------------------
    always #2.5 clk = ~clk;
    // A pulse standing two cycles counts twice, so width is checked too
    always @(posedge clk) begin
        cycles++;
        for (int p = 0; p < 2; p++)
            if (autoneg_restart[p] === 1'b1) n_rst[p]++;
        if (cycles == 10000) begin
            n_errors++;
            stop_test();
        end
    end
    // ----------------------------
    // Helpers
    // ----------------------------
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Byte address of register b (0 = A, 1 = B) of port p, port 2 reserved
    function automatic logic [9:0] adr(input int p, input logic b);
        logic [7:0] idx;
        idx = (p == 0) ? `PPLC_IDX_P1_CTL_A : (p == 1) ? `PPLC_IDX_P2_CTL_A
                                                       : `PPLC_IDX_P3_CTL_A;
        return {idx + {7'h00, b}, 2'h0};
    endfunction
    // One APB transfer; the request stands until pready is sampled high
    task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d,
                       input logic [7:0] ed, input logic ee);
        logic [31:0] r;
        int          k;
        r = $random(seed);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {r[31:8], d};
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        chk({pready, pslverr}, {1'b1, ee});
        if (!w) chk(prdata, {24'h000000, ed});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input int p, input logic b, input logic [7:0] v);
        acc(1'b1, adr(p, b), v, 8'h00, 1'b0);
        if (b) sb[p] = v;
        else sa[p] = v;
        if (b && v[`PPLC_B_RESTART]) e_rst[p]++;
    endtask
    task automatic check_port(input int p);
        logic frc;
        frc = !sa[p][`PPLC_A_AN_EN] || autoneg_failed[p] === 1'b1;
        chk(autoneg_enable[p], sa[p][7]);
        chk(full_duplex[p], frc ? sa[p][5] : partner_full_duplex[p]);
        chk(speed_100[p], frc ? sa[p][6] : partner_speed_100[p]);
        chk({advert_pause[p], advert_ability[4*p +: 4]}, sa[p][4:0]);
        chk({port_led_one[p], port_led_zero[p]},
            {led_one_raw[p], led_zero_raw[p]} | {2{sb[p][7]}});
        chk(tx_enable[p], !sb[p][6]);
        chk(far_end_fault_enable[p], !sb[p][4]);
        chk(auto_mdix_enable[p], !sb[p][2]);
        chk(mdi_mode[p], sb[p][2] ? sb[p][1] : auto_mdi_detect[p]);
        chk({power_down[p], loopback[p]}, {sb[p][3], sb[p][0]});
        chk(n_rst[p], e_rst[p]);
    endtask
    // Lets negotiation finish, then compares both ports and readback
    task automatic settle();
        repeat (16) @(posedge clk);
        @(negedge clk);
        for (int p = 0; p < 2; p++) check_port(p);
        for (int p = 0; p < 2; p++) begin
            acc(1'b0, adr(p, 0), 8'h00, sa[p], 1'b0);
            acc(1'b0, adr(p, 1), 8'h00, sb[p], 1'b0);
        end
    endtask
    // ----------------------------
    // Main sequence
    // ----------------------------
    initial begin
        logic [7:0] va, vb;
        int         p;
        {duplex_strap_port2, duplex_strap_port1} <= 2'($random(seed));
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk({tx_enable, far_end_fault_enable, auto_mdix_enable, advert_ability},
            14'h3FFF);
        chk({autoneg_restart, mdi_mode, pready}, 5'h00);
        @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        sa[0] = {2'h3, duplex_strap_port1, 5'h1F};
        sa[1] = {2'h3, duplex_strap_port2, 5'h1F};
        sb[0] = 8'h00;
        sb[1] = 8'h00;
        settle();
        // Reserved port and bad addresses change nothing
        acc(1'b1, adr(2, 1), 8'hFF, 8'h00, 1'b0);
        acc(1'b0, adr(2, 1), 8'h00, 8'h00, 1'b0);
        acc(1'b1, 10'h000, 8'hFF, 8'h00, 1'b1);
        acc(1'b1, adr(0, 1) | 10'h001, 8'hFF, 8'h00, 1'b1);
        // Forced port with duplex cleared
        wreg(0, 0, 8'h40);
        wreg(1, 1, 8'h24);
        settle();
        repeat (40) begin
            p = {$random(seed)} % 2;
            va = $random(seed);
            vb = $random(seed);
            @(posedge clk);
            cfg_fail <= 2'($random(seed));
            cfg_fd <= 2'($random(seed));
            cfg_100 <= 2'($random(seed));
            led_one_raw <= 2'($random(seed));
            led_zero_raw <= 2'($random(seed));
            auto_mdi_detect <= 2'($random(seed));
            wreg(p, 0, va);
            wreg(p, 1, vb);
            settle();
        end
        stop_test();
    end
endmodule
